// [design/acc_pkg.sv]
// Purpose: Shared constants for the auxiliary converter control block.
// Assumes: Byte-wide register port, one device clock.
// Notes:   Result locations and the pin-sync fields sit at spare offsets.
`default_nettype none
package acc_pkg;
  // Register offsets.
  localparam logic [7:0] ACC_FS_REF_ADDR  = 8'h17;
  localparam logic [7:0] ACC_ADC_CTRL_ADDR = 8'h22;
  localparam logic [7:0] ACC_DAC_A_ADDR   = 8'h24;
  localparam logic [7:0] ACC_DAC_B_ADDR   = 8'h25;
  localparam logic [7:0] ACC_DAC_C_ADDR   = 8'h26;
  localparam logic [7:0] ACC_DAC_UPD_ADDR = 8'h28;
  localparam logic [7:0] ACC_DAC_PWR_ADDR = 8'h29;
  localparam logic [7:0] ACC_RES_A1_HI    = 8'h2a;
  localparam logic [7:0] ACC_RES_A1_LO    = 8'h2b;
  localparam logic [7:0] ACC_RES_A2_HI    = 8'h2c;
  localparam logic [7:0] ACC_RES_A2_LO    = 8'h2d;
  localparam logic [7:0] ACC_RES_B_HI     = 8'h2e;
  localparam logic [7:0] ACC_RES_B_LO     = 8'h2f;
  // Field positions.
  localparam int ACC_REF_FS_BIT   = 0;
  localparam int ACC_REF_EN_BIT   = 1;
  localparam int ACC_DAC_FS_LSB   = 2;
  localparam int ACC_START_A_BIT  = 0;
  localparam int ACC_SEL_A_BIT    = 1;
  localparam int ACC_REFSEL_A_BIT = 2;
  localparam int ACC_START_B_BIT  = 3;
  localparam int ACC_REFSEL_B_BIT = 5;
  localparam int ACC_SLAVE_BIT    = 7;
  localparam int ACC_PINSYNC_BIT  = 6;
  localparam int ACC_PINSEL_LSB   = 3;
  // Values after reset and at conversion start.
  localparam logic [7:0] ACC_REG_RST   = 8'h00;
  localparam logic [9:0] ACC_CODE_RST  = 10'h000;
  localparam logic [9:0] ACC_TRIAL_MSB = 10'h200;
  // Cycle counts.
  localparam int          ACC_AUX_DIV     = 4;
  localparam logic [3:0]  ACC_LAST_BIT    = 4'h9;
  localparam int          ACC_CONV_TICKS  = 12;
  typedef enum logic [1:0] {ACC_IDLE, ACC_SETUP, ACC_DECIDE, ACC_STORE}
    acc_sar_t;
endpackage
`default_nettype wire

// [design/acc_aux_converter_control.sv]
// Purpose: Register file and sequencing for three voltage DACs and two
//          successive-approximation monitor ADCs.
// Assumes: The serial port core presents decoded byte accesses; the ADC
//          comparators are on-chip logic in the same clock domain.
// Notes:   One conversion takes twelve ticks of the divided auxiliary clock.
`default_nettype none
// How it works
// - After reset every auxiliary converter stays disabled and powered down.
// - ADC input switch closes only while its conversion is running.
// - Each DAC stays powered down until its power-up bit in 0x29 is set.
// - Each 8-bit DAC takes its straight binary code from registers 0x24-0x26.
// - Each DAC has its own two-bit full-scale select field in 0x17.
// - Without a sync mode, a DAC updates right after its code write.
// - Writing one to bit 7 of 0x28 enters register-triggered mode.
// - In that mode, update bits 2-0 of 0x28 load DACs C, B, A.
// - Selected DACs update together on a rising edge of the power-down pin.
// - Two independent 10-bit successive-approximation ADCs are provided.
// - ADCs stay powered down and power up automatically for each conversion.
// - Bit 1 of 0x22 picks which pin feeds monitor converter A.
// - That select bit resets low, which routes the second input pin.
// - By default both ADCs use the buffered supply as full-scale reference.
// - Enable and full-scale bits in 0x17 pick internal 2.5 V or 3.0 V.
// - A set reference-select bit without internal enable uses external pin.
// - Conversions start and results return through the register map.
// - Enable, full-scale and channel select all one give internal 2.5 V.
// - Writing one to bit 0 or bit 3 of 0x22 starts A or B.
// - A finished 10-bit result lands in a two-address slot per input.
module acc_aux_converter_control
  import acc_pkg::*;
#(
  parameter int AUX_DIV = acc_pkg::ACC_AUX_DIV
)
(
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       srst,
  // Register access from the serial port core.
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  // Transmit power-down pin.
  input  wire logic       tx_powerdown_pin,
  // Auxiliary DAC controls.
  output logic      [7:0] voltage_out_channel_a,
  output logic      [7:0] voltage_out_channel_b,
  output logic      [7:0] voltage_out_channel_c,
  output logic      [2:0] dac_power_up,
  output logic      [5:0] dac_fullscale_select,
  // Auxiliary ADC controls.
  input  wire logic [1:0] adc_comp_high,
  output logic      [1:0] adc_power_on,
  output logic      [9:0] monitor_converter_a_trial,
  output logic      [9:0] monitor_converter_b_trial,
  output logic            first_converter_input_one_connect,
  output logic            first_converter_input_two_connect,
  output logic            monitor_converter_b_connect,
  // Reference routing.
  output logic      [1:0] adc_ref_supply_buffer,
  output logic      [1:0] adc_ref_internal,
  output logic      [1:0] adc_ref_external,
  output logic            internal_reference_enable,
  output logic            internal_reference_fullscale
);
  import acc_pkg::*;

  // One SAR step: keep or drop the bit under test, then try the next one.
  function automatic logic [9:0] sar_step(input logic [9:0] trial,
                                          input logic       keep,
                                          input logic [3:0] idx);
    logic [9:0] mask;
    mask = ACC_TRIAL_MSB >> idx;
    sar_step = (keep ? trial : (trial & ~mask)) | (mask >> 1);
  endfunction
  logic [7:0] fs_ref;
  logic [7:0] adc_ctrl;
  logic [7:0] upd_ctrl;
  logic [7:0] pending [3];
  logic [7:0] active  [3];
  logic [9:0] res_a1;
  logic [9:0] res_a2;
  logic [9:0] res_b;
  logic [9:0] trial   [2];
  logic [3:0] bit_idx [2];
  acc_sar_t   state   [2];
  logic [7:0] div_cnt;
  logic       tick;
  logic       pin_s1;
  logic       pin_s2;
  logic       pin_s3;
  logic       pin_level;
  logic       pin_rise;
  // Decoding.
  wire wr_fs   = reg_write && reg_addr == ACC_FS_REF_ADDR;
  wire wr_adc  = reg_write && reg_addr == ACC_ADC_CTRL_ADDR;
  wire wr_upd  = reg_write && reg_addr == ACC_DAC_UPD_ADDR;
  wire wr_pwr  = reg_write && reg_addr == ACC_DAC_PWR_ADDR;
  wire slave   = upd_ctrl[ACC_SLAVE_BIT];
  wire pinsync = upd_ctrl[ACC_PINSYNC_BIT];
  wire [2:0] pinsel = upd_ctrl[ACC_PINSEL_LSB +: 3];
  wire ref_en  = fs_ref[ACC_REF_EN_BIT];
  wire [1:0] refsel = {adc_ctrl[ACC_REFSEL_B_BIT],
                       adc_ctrl[ACC_REFSEL_A_BIT]};
  wire sel_start = reg_wdata[ACC_SEL_A_BIT];
  wire [1:0] busy = {state[1] != ACC_IDLE, state[0] != ACC_IDLE};
  wire [1:0] go = {wr_adc && reg_wdata[ACC_START_B_BIT] && !busy[1],
                   wr_adc && reg_wdata[ACC_START_A_BIT] && !busy[0]};
  wire [1:0] done = {state[1] == ACC_STORE && tick,
                     state[0] == ACC_STORE && tick};
  wire [7:0] ctrl_rd = {adc_ctrl[7:4], busy[1], adc_ctrl[2:1], busy[0]};
  // Results and status read back through the register map.
  wire [7:0] rd_mux =
    reg_addr == ACC_FS_REF_ADDR   ? fs_ref :
    reg_addr == ACC_ADC_CTRL_ADDR ? ctrl_rd :
    reg_addr == ACC_DAC_A_ADDR    ? pending[0] :
    reg_addr == ACC_DAC_B_ADDR    ? pending[1] :
    reg_addr == ACC_DAC_C_ADDR    ? pending[2] :
    reg_addr == ACC_DAC_UPD_ADDR  ? {upd_ctrl[7:3], 3'h0} :
    reg_addr == ACC_DAC_PWR_ADDR  ? {5'h00, dac_power_up} :
    reg_addr == ACC_RES_A1_HI     ? res_a1[9:2] :
    reg_addr == ACC_RES_A1_LO     ? {6'h00, res_a1[1:0]} :
    reg_addr == ACC_RES_A2_HI     ? res_a2[9:2] :
    reg_addr == ACC_RES_A2_LO     ? {6'h00, res_a2[1:0]} :
    reg_addr == ACC_RES_B_HI      ? res_b[9:2] :
    reg_addr == ACC_RES_B_LO      ? {6'h00, res_b[1:0]} : 8'h00;
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      fs_ref       <= ACC_REG_RST;
      adc_ctrl     <= ACC_REG_RST;
      upd_ctrl     <= ACC_REG_RST;
      dac_power_up <= 3'h0;
      reg_rdata    <= ACC_REG_RST;
    end
    else
    begin
      if (wr_fs)
        fs_ref <= reg_wdata;
      if (wr_adc)
        adc_ctrl <= {reg_wdata[7:4], 1'b0, reg_wdata[2:1], 1'b0};
      if (wr_upd)
        upd_ctrl <= {reg_wdata[7:3], 3'h0};
      if (wr_pwr)
        dac_power_up <= reg_wdata[2:0];
      if (reg_read)
        reg_rdata <= rd_mux;
    end
  end
  // Full-scale selects and reference routing.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      dac_fullscale_select         <= 6'h00;
      adc_ref_supply_buffer        <= 2'h3;
      adc_ref_internal             <= 2'h0;
      adc_ref_external             <= 2'h0;
      internal_reference_enable    <= 1'b0;
      internal_reference_fullscale <= 1'b0;
    end
    else
    begin
      dac_fullscale_select         <= fs_ref[ACC_DAC_FS_LSB +: 6];
      adc_ref_supply_buffer        <= ~refsel;
      adc_ref_internal             <= refsel & {2{ref_en}};
      adc_ref_external             <= refsel & {2{!ref_en}};
      internal_reference_enable    <= ref_en;
      internal_reference_fullscale <= fs_ref[ACC_REF_FS_BIT];
    end
  end
  // Power-down pin: three stages, a change counts once stages 2 and 3 agree.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pin_s1    <= 1'b0;
      pin_s2    <= 1'b0;
      pin_s3    <= 1'b0;
      pin_level <= 1'b0;
      pin_rise  <= 1'b0;
    end
    else
    begin
      pin_s1 <= tx_powerdown_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3)
        pin_level <= pin_s3;
      pin_rise <= pin_s2 == pin_s3 && pin_s3 && !pin_level;
    end
  end
  // DAC codes: pending on write, active on the chosen update event.
  for (genvar i = 0; i < 3; i++)
  begin : g_dac
    wire wr_code = reg_write && reg_addr == ACC_DAC_A_ADDR + 8'(i);
    wire by_pin  = pinsync && pinsel[i];
    wire imm     = !slave && !by_pin;
    wire trig    = slave ? (wr_upd && reg_wdata[i])
                         : (by_pin && pin_rise);
    always_ff @(posedge clock)
    begin
      if (srst)
      begin
        pending[i] <= ACC_REG_RST;
        active[i]  <= ACC_REG_RST;
      end
      else
      begin
        if (wr_code)
          pending[i] <= reg_wdata;
        if (wr_code && imm)
          active[i] <= reg_wdata;
        else if (trig)
          active[i] <= pending[i];
      end
    end
  end
  assign voltage_out_channel_a = active[0];
  assign voltage_out_channel_b = active[1];
  assign voltage_out_channel_c = active[2];

  // Auxiliary ADC clock as a one-cycle enable.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      div_cnt <= 8'h00;
      tick    <= 1'b0;
    end
    else
    begin
      tick    <= div_cnt == 8'(AUX_DIV - 1);
      div_cnt <= div_cnt == 8'(AUX_DIV - 1) ? 8'h00 : div_cnt + 8'h01;
    end
  end

  // Two independent SAR sequencers: setup, ten decisions, store.
  for (genvar i = 0; i < 2; i++)
  begin : g_sar
    always_ff @(posedge clock)
    begin
      if (srst)
      begin
        state[i]   <= ACC_IDLE;
        trial[i]   <= ACC_CODE_RST;
        bit_idx[i] <= 4'h0;
      end
      else
      begin
        unique case (state[i])
          ACC_IDLE:
            if (go[i])
            begin
              state[i] <= ACC_SETUP;
              trial[i] <= ACC_TRIAL_MSB;
            end
          ACC_SETUP:
            if (tick)
            begin
              state[i]   <= ACC_DECIDE;
              bit_idx[i] <= 4'h0;
            end
          ACC_DECIDE:
            if (tick)
            begin
              trial[i]   <= sar_step(trial[i], adc_comp_high[i], bit_idx[i]);
              bit_idx[i] <= bit_idx[i] + 4'h1;
              if (bit_idx[i] == ACC_LAST_BIT)
                state[i] <= ACC_STORE;
            end
          ACC_STORE:
            if (tick)
              state[i] <= ACC_IDLE;
        endcase
      end
    end
  end
  assign monitor_converter_a_trial = trial[0];
  assign monitor_converter_b_trial = trial[1];

  // Power, input switches and result slots.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      adc_power_on                      <= 2'h0;
      first_converter_input_one_connect <= 1'b0;
      first_converter_input_two_connect <= 1'b0;
      monitor_converter_b_connect       <= 1'b0;
      res_a1 <= ACC_CODE_RST;
      res_a2 <= ACC_CODE_RST;
      res_b  <= ACC_CODE_RST;
    end
    else
    begin
      adc_power_on <= (adc_power_on | go) & ~done;
      if (go[0])
      begin
        first_converter_input_one_connect <= sel_start;
        first_converter_input_two_connect <= !sel_start;
      end
      else if (done[0])
      begin
        first_converter_input_one_connect <= 1'b0;
        first_converter_input_two_connect <= 1'b0;
      end
      if (go[1])
        monitor_converter_b_connect <= 1'b1;
      else if (done[1])
        monitor_converter_b_connect <= 1'b0;
      if (done[0] && first_converter_input_one_connect)
        res_a1 <= trial[0];
      if (done[0] && first_converter_input_two_connect)
        res_a2 <= trial[0];
      if (done[1])
        res_b <= trial[1];
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  reset_off_a : assert property (
    $fell(srst) |-> dac_power_up == 3'h0 && adc_power_on == 2'h0
                    && !first_converter_input_two_connect)
    else $error("converters not off after reset");
  switch_busy_a : assert property (
    (first_converter_input_one_connect || first_converter_input_two_connect)
      == adc_power_on[0] && monitor_converter_b_connect == adc_power_on[1])
    else $error("input switch out of step with conversion");
  dac_power_a : assert property (
    wr_pwr |=> dac_power_up == $past(reg_wdata[2:0]))
    else $error("DAC power-up bits not taken");
  dac_immediate_a : assert property (
    g_dac[0].wr_code && !slave && !pinsel[0] |=>
      voltage_out_channel_a == $past(reg_wdata))
    else $error("immediate DAC update missing");
  slave_hold_a : assert property (
    slave && g_dac[1].wr_code && !wr_upd |=>
      voltage_out_channel_b == $past(voltage_out_channel_b))
    else $error("slave mode DAC changed without trigger");
  slave_update_a : assert property (
    slave && wr_upd && reg_wdata[2] |=>
      voltage_out_channel_c == $past(pending[2]))
    else $error("slave update of DAC C missing");
  pin_update_a : assert property (
    !slave && pinsync && pinsel[0] && pin_rise |=>
      voltage_out_channel_a == $past(pending[0]))
    else $error("pin edge update missing");
  conv_length_a : assert property (
    go[1] |=> adc_power_on[1] [*8] ##[1:60] !adc_power_on[1])
    else $error("conversion length out of bounds");
  sel_route_a : assert property (
    go[0] && !sel_start |=> first_converter_input_two_connect)
    else $error("select low did not route input two");
  ext_ref_a : assert property (
    refsel[1] && !ref_en |=> adc_ref_external[1] && !adc_ref_supply_buffer[1])
    else $error("external reference not selected");
  result_slot_a : assert property (
    done[0] && first_converter_input_two_connect |=> res_a2 == $past(trial[0]))
    else $error("result not stored in second input slot");
endmodule
`default_nettype wire

// [sim/acc_analog_model.sv]
// Purpose: Analog pin model that answers the monitor comparators.
// Assumes: Pin levels are 10-bit codes chosen by the bench.
// Notes:   An open switch leaves the comparator floating, shown as a toggle.
`default_nettype none
module acc_analog_model
(
  // Clock.
  input  wire logic       clock,
  // Switch and trial state from the device.
  input  wire logic       in_one_connect,
  input  wire logic       in_two_connect,
  input  wire logic       b_connect,
  input  wire logic [9:0] trial_a,
  input  wire logic [9:0] trial_b,
  // Levels present on the pins.
  input  wire logic [9:0] level_one,
  input  wire logic [9:0] level_two,
  input  wire logic [9:0] level_b,
  // Comparator results.
  output logic      [1:0] comp_high
);
  timeunit 1ns;
  timeprecision 1ps;
  logic float_q = 1'b0;
  always_ff @(posedge clock)
  begin
    float_q <= ~float_q;
  end
  // A converter sees a pin only while its switch is closed.
  assign comp_high[0] = in_one_connect ? (level_one >= trial_a) :
                        in_two_connect ? (level_two >= trial_a) : float_q;
  assign comp_high[1] = b_connect ? (level_b >= trial_b) : ~float_q;
endmodule
`default_nettype wire

// [sim/acc_testbench.sv]
// Purpose: Register level test of the auxiliary converter control block.
// Assumes: Byte accesses by one-cycle strobes, default divider of four.
// Notes:   Results are expected to equal the pin levels exactly.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import acc_pkg::*;
  logic       clock = 1'b0;
  logic       srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic       tx_powerdown_pin = 1'b0;
  logic [9:0] level_one = 10'h3ff;
  logic [9:0] level_two = 10'h2c5;
  logic [9:0] level_b = 10'h13a;
  logic [7:0] reg_rdata, out_a, out_b, out_c;
  logic [5:0] fs_sel;
  logic [2:0] dac_power_up;
  logic [1:0] comp_high, power_on, ref_sup, ref_int, ref_ext;
  logic [9:0] trial_a, trial_b;
  logic       in_one, in_two, b_conn, ref_en, ref_fs;
  int         errors = 0;
  int         checks_done = 0;
  initial
  begin
    forever #5 clock = ~clock;
  end
  acc_aux_converter_control dut (
    .clock(clock), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .tx_powerdown_pin(tx_powerdown_pin),
    .voltage_out_channel_a(out_a), .voltage_out_channel_b(out_b),
    .voltage_out_channel_c(out_c), .dac_power_up(dac_power_up),
    .dac_fullscale_select(fs_sel), .adc_comp_high(comp_high),
    .adc_power_on(power_on), .monitor_converter_a_trial(trial_a),
    .monitor_converter_b_trial(trial_b),
    .first_converter_input_one_connect(in_one),
    .first_converter_input_two_connect(in_two),
    .monitor_converter_b_connect(b_conn), .adc_ref_supply_buffer(ref_sup),
    .adc_ref_internal(ref_int), .adc_ref_external(ref_ext),
    .internal_reference_enable(ref_en),
    .internal_reference_fullscale(ref_fs));
  acc_analog_model model (
    .clock(clock), .in_one_connect(in_one), .in_two_connect(in_two),
    .b_connect(b_conn), .trial_a(trial_a), .trial_b(trial_b),
    .level_one(level_one), .level_two(level_two), .level_b(level_b),
    .comp_high(comp_high));
  task automatic end_sim();
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Waits for both converters to power down again.
  task automatic wait_idle();
    int n;
    n = 0;
    while (power_on !== 2'b00 && n < 200)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 200)
    begin
      errors++;
      end_sim();
    end
  endtask
  initial
  begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    #1;
    check(dac_power_up, 3'b000);
    check(power_on, 2'b00);
    check({in_one, in_two, b_conn}, 3'b000);
    check({ref_int, ref_ext, ref_sup}, 6'b000011);
    rd(ACC_ADC_CTRL_ADDR, 8'h00);
    rd(ACC_DAC_UPD_ADDR, 8'h00);
    rd(8'h30, 8'h00);
    wr(ACC_DAC_A_ADDR, 8'h5a);
    check(out_a, 8'h5a);
    wr(ACC_DAC_B_ADDR, 8'hff);
    check(out_b, 8'hff);
    wr(ACC_DAC_C_ADDR, 8'h01);
    check(out_c, 8'h01);
    rd(ACC_DAC_B_ADDR, 8'hff);
    wr(ACC_DAC_PWR_ADDR, 8'h05);
    check(dac_power_up, 3'b101);
    wr(ACC_FS_REF_ADDR, 8'he4);
    cyc(1);
    check(fs_sel, 6'b111001);
    wr(ACC_ADC_CTRL_ADDR, 8'h24);
    wr(ACC_FS_REF_ADDR, 8'h1b);
    cyc(1);
    check(fs_sel, 6'b000110);
    check({ref_en, ref_fs}, 2'b11);
    check({ref_int, ref_ext, ref_sup}, 6'b110000);
    wr(ACC_FS_REF_ADDR, 8'h02);
    cyc(1);
    check({ref_en, ref_fs, ref_int}, 4'b1011);
    wr(ACC_FS_REF_ADDR, 8'h00);
    cyc(1);
    check({ref_int, ref_ext, ref_sup}, 6'b001100);
    wr(ACC_ADC_CTRL_ADDR, 8'h20);
    cyc(1);
    check({ref_ext, ref_sup}, 4'b1001);
    wr(ACC_DAC_UPD_ADDR, 8'h80);
    wr(ACC_DAC_A_ADDR, 8'h11);
    wr(ACC_DAC_C_ADDR, 8'h33);
    check(out_a, 8'h5a);
    rd(ACC_DAC_A_ADDR, 8'h11);
    wr(ACC_DAC_UPD_ADDR, 8'h81);
    check({out_a, out_c}, 16'h1101);
    wr(ACC_DAC_UPD_ADDR, 8'h84);
    check({out_c, out_b}, 16'h33ff);
    rd(ACC_DAC_UPD_ADDR, 8'h80);
    wr(ACC_DAC_UPD_ADDR, 8'h68);
    wr(ACC_DAC_A_ADDR, 8'h77);
    wr(ACC_DAC_B_ADDR, 8'h88);
    wr(ACC_DAC_C_ADDR, 8'h99);
    check({out_a, out_b, out_c}, 24'h118833);
    @(posedge clock);
    tx_powerdown_pin <= 1'b1;
    cyc(3);
    check(out_a, 8'h11);
    cyc(3);
    check({out_a, out_c}, 16'h7799);
    wr(ACC_DAC_UPD_ADDR, 8'h00);
    wr(ACC_ADC_CTRL_ADDR, 8'h09);
    check({power_on, in_one, in_two, b_conn}, 5'b11011);
    check({trial_a, trial_b}, {ACC_TRIAL_MSB, ACC_TRIAL_MSB});
    rd(ACC_ADC_CTRL_ADDR, 8'h09);
    wait_idle();
    check({in_one, in_two, b_conn}, 3'b000);
    rd(ACC_RES_A2_HI, 8'hb1);
    rd(ACC_RES_A2_LO, 8'h01);
    rd(ACC_RES_B_HI, 8'h4e);
    rd(ACC_RES_B_LO, 8'h02);
    rd(ACC_ADC_CTRL_ADDR, 8'h00);
    wr(ACC_ADC_CTRL_ADDR, 8'h03);
    check({power_on, in_one, in_two}, 4'b0110);
    wait_idle();
    rd(ACC_RES_A1_HI, 8'hff);
    rd(ACC_RES_A1_LO, 8'h03);
    rd(ACC_ADC_CTRL_ADDR, 8'h02);
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    #1;
    check({out_a, out_b, out_c}, 24'h000000);
    check({dac_power_up, power_on, in_one, in_two}, 7'h00);
    end_sim();
  end
endmodule
`default_nettype wire
